// ### rbst_top.sv
// rbst_top: remote binary signal transfer, four fast and 24 background
// items broadcast to all peers, received items merged per index.
// assumes a link layer on clk that takes frames by valid/ready and
// delivers per-peer frames, fault and topology status on clk.
//
// Overview of operation
// R1: carries up to 28 binary items to peers
// R2: four fast items sent first, high priority
// R3: 24 background items fill the free slots
// R4: fast input n drives fast output n remotely
// R5: background input n drives output n remotely
// R6: internal indication may replace any input
// R7: transfer continues when device logged out
// R8: peer presence reported only while peer active
// R9: on link fault hold state, then clear
// R10: every frame broadcast, no destination selection
// R11: outputs inactive until first valid peer data
`timescale 1ns/1ns
module rbst_top
  import rbst_pkg::*;
#(
  parameter int TICK_CYCLES = RBST_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // local binary input pins
  input wire logic [RBST_NUM_FAST-1:0] fastTripIn,
  input wire logic [RBST_NUM_SLOW-1:0] slowSignalIn,
  // internal indications from the user logic stage
  input wire logic [RBST_NUM_FAST-1:0] userFastInd,
  input wire logic [RBST_NUM_SLOW-1:0] userSlowInd,
  input wire logic [RBST_NUM_FAST-1:0] userFastSel,
  input wire logic [RBST_NUM_SLOW-1:0] userSlowSel,
  // transmit link
  output logic txValid,
  input wire logic txReady,
  output rbst_frame_t txFrame,
  // receive link, one lane per peer
  input wire logic [RBST_NUM_PEERS-1:0] rxValid,
  input wire rbst_frame_t [RBST_NUM_PEERS-1:0] rxFrame,
  input wire logic [RBST_NUM_PEERS-1:0] linkFault,
  input wire logic [RBST_NUM_PEERS-1:0] peerActive,
  // settings
  input wire logic [RBST_HOLD_W-1:0] holdTimeMs,
  // received outputs and status
  output logic [RBST_NUM_FAST-1:0] fastTripOut,
  output logic [RBST_NUM_SLOW-1:0] slowSignalOut,
  output logic [RBST_NUM_PEERS-1:0] peerPresentFlag
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  logic [RBST_NUM_FAST-1:0] fastMeta_q, fastSync_q;
  logic [RBST_NUM_SLOW-1:0] slowMeta_q, slowSync_q;
  logic [RBST_NUM_FAST-1:0] fastNow, lastFast_q, lastFast_d;
  logic [RBST_NUM_SLOW-1:0] slowNow;
  logic txValid_q, txValid_d, turn_q, turn_d, loadSlot;
  rbst_frame_t txFrame_q, txFrame_d;
  logic [TW-1:0] div_q, div_d;
  logic msTick_q, msTick_d;
  logic [RBST_NUM_FAST-1:0] peerFast [RBST_NUM_PEERS];
  logic [RBST_NUM_SLOW-1:0] peerSlow [RBST_NUM_PEERS];
  logic [RBST_NUM_FAST-1:0] fastOr, fastOut_q;
  logic [RBST_NUM_SLOW-1:0] slowOr, slowOut_q;
  logic [RBST_NUM_PEERS-1:0] present_q;

  // pin synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fastMeta_q <= RBST_FAST_RST;
      fastSync_q <= RBST_FAST_RST;
      slowMeta_q <= RBST_SLOW_RST;
      slowSync_q <= RBST_SLOW_RST;
    end else begin
      fastMeta_q <= fastTripIn;
      fastSync_q <= fastMeta_q;
      slowMeta_q <= slowSignalIn;
      slowSync_q <= slowMeta_q;
    end
  end

  // source select: pin or internal indication per item
  assign fastNow = (userFastSel & userFastInd) | (~userFastSel & fastSync_q); // R6
  assign slowNow = (userSlowSel & userSlowInd) | (~userSlowSel & slowSync_q); // R6

  // transmit scheduler; no login gating, one stream to all peers
  assign loadSlot = !txValid_q || txReady; // R7 R10
  always_comb begin
    txValid_d = txValid_q;
    txFrame_d = txFrame_q;
    lastFast_d = lastFast_q;
    turn_d = turn_q;
    if (loadSlot) begin
      txValid_d = 1'b1;
      if (fastNow != lastFast_q || turn_q) begin
        txFrame_d.isFast = 1'b1; // R2
        txFrame_d.payload = RBST_NUM_SLOW'(fastNow); // R1 R4
        lastFast_d = fastNow;
        turn_d = 1'b0;
      end else begin
        txFrame_d.isFast = 1'b0; // R3
        txFrame_d.payload = slowNow; // R1 R5
        turn_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txValid_q <= 1'b0;
      txFrame_q <= RBST_FRAME_RST;
      lastFast_q <= RBST_FAST_RST;
      turn_q <= 1'b1;
    end else begin
      txValid_q <= txValid_d;
      txFrame_q <= txFrame_d;
      lastFast_q <= lastFast_d;
      turn_q <= turn_d;
    end
  end

  assign txValid = txValid_q;
  assign txFrame = txFrame_q;

  // millisecond tick for the hold timer
  always_comb begin
    msTick_d = (div_q == TICK_LAST);
    div_d = msTick_d ? '0 : div_q + TW'(1);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      msTick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      msTick_q <= msTick_d;
    end
  end

  // one receiver per peer
  for (genvar p = 0; p < RBST_NUM_PEERS; p++) begin : gPeer
    rbst_peer_rx uRx (
      .clk(clk),
      .reset_n(reset_n),
      .rxValid(rxValid[p]),
      .rxFrame(rxFrame[p]),
      .linkFault(linkFault[p]),
      .msTick(msTick_q),
      .holdTimeMs(holdTimeMs),
      .fastOut(peerFast[p]),
      .slowOut(peerSlow[p])
    );
  end

  // merge peers by index
  always_comb begin
    fastOr = RBST_FAST_RST;
    slowOr = RBST_SLOW_RST;
    for (int p = 0; p < RBST_NUM_PEERS; p++) begin
      fastOr = fastOr | peerFast[p]; // R4
      slowOr = slowOr | peerSlow[p]; // R5
    end
  end

  // registered outputs and presence flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fastOut_q <= RBST_FAST_RST;
      slowOut_q <= RBST_SLOW_RST;
      present_q <= '0;
    end else begin
      fastOut_q <= fastOr;
      slowOut_q <= slowOr;
      present_q <= peerActive; // R8
    end
  end

  assign fastTripOut = fastOut_q;
  assign slowSignalOut = slowOut_q;
  assign peerPresentFlag = present_q;

  // checks
  tx_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
    txValid && !txReady |=> txValid && $stable(txFrame))
    else $error("frame changed before it was taken");
  fast_first_a: assert property (@(posedge clk) disable iff (!reset_n) // R2
    loadSlot && fastNow != lastFast_q |=> txFrame.isFast
      && txFrame.payload[RBST_FAST_MSB:RBST_FAST_LSB] == $past(fastNow))
    else $error("changed fast item not sent first");
  slow_fill_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
    txValid && txReady && txFrame.isFast && fastNow == lastFast_q
      |=> !txFrame.isFast)
    else $error("free slot not used for background items");
  present_track_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
    ##1 peerPresentFlag == $past(peerActive))
    else $error("presence flag does not follow topology");
  out_merge_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
    ##1 fastTripOut == $past(fastOr) && slowSignalOut == $past(slowOr))
    else $error("received outputs do not match merged peers");
  tick_gap_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
    msTick_q |=> !msTick_q)
    else $error("hold tick wider than one cycle");
  fast_tx_c: cover property (@(posedge clk) disable iff (!reset_n)
    txValid && txReady && txFrame.isFast);
  slow_tx_c: cover property (@(posedge clk) disable iff (!reset_n)
    txValid && txReady && !txFrame.isFast);
  trip_rx_c: cover property (@(posedge clk) disable iff (!reset_n)
    fastTripOut != 4'h0);
endmodule : rbst_top

// ### rbst_pkg.sv
// rbst_pkg: constants and carrier types for the remote binary signal
// transfer block; no assumptions beyond a single 20 MHz clock.
package rbst_pkg;
  // item counts
  localparam int RBST_NUM_FAST = 4;
  localparam int RBST_NUM_SLOW = 24;
  localparam int RBST_NUM_PEERS = 2;
  // field positions inside a frame payload
  localparam int RBST_FAST_LSB = 0;
  localparam int RBST_FAST_MSB = RBST_FAST_LSB + RBST_NUM_FAST - 1;
  // hold time setting width (milliseconds)
  localparam int RBST_HOLD_W = 16;
  // timing: clock period and hold-timer tick
  localparam int RBST_CLK_PERIOD_NS = 50;
  localparam int RBST_TICK_NS = 1000000;
  localparam int RBST_TICK_CYCLES = RBST_TICK_NS / RBST_CLK_PERIOD_NS;
  // reset values
  localparam logic [RBST_NUM_FAST-1:0] RBST_FAST_RST = 4'h0;
  localparam logic [RBST_NUM_SLOW-1:0] RBST_SLOW_RST = 24'h000000;
  localparam logic [RBST_HOLD_W-1:0] RBST_CNT_RST = 16'h0000;

  // one link frame: high-priority or background payload
  typedef struct packed {
    logic isFast;
    logic [RBST_NUM_SLOW-1:0] payload;
  } rbst_frame_t;

  localparam rbst_frame_t RBST_FRAME_RST = '{isFast: 1'b0, payload: 24'h0};

  // receiver state per peer
  typedef enum logic [1:0] {RX_WAIT, RX_LIVE, RX_HOLD} rbst_rx_state_t;
endpackage : rbst_pkg

// ### rbst_peer_rx.sv
// rbst_peer_rx: received item store for one peer with link-loss hold timer.
// assumes frames, fault and tick come from logic on the same clock.
`timescale 1ns/1ns
module rbst_peer_rx
  import rbst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link side
  input wire logic rxValid,
  input wire rbst_frame_t rxFrame,
  input wire logic linkFault,
  // timing
  input wire logic msTick,
  input wire logic [RBST_HOLD_W-1:0] holdTimeMs,
  // received items
  output logic [RBST_NUM_FAST-1:0] fastOut,
  output logic [RBST_NUM_SLOW-1:0] slowOut
);
  rbst_rx_state_t state_q, state_d;
  logic [RBST_HOLD_W-1:0] cnt_q, cnt_d;
  logic [RBST_NUM_FAST-1:0] fast_q, fast_d;
  logic [RBST_NUM_SLOW-1:0] slow_q, slow_d;

  // next state: store frames, hold on fault, clear on expiry
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fast_d = fast_q;
    slow_d = slow_q;
    case (state_q)
      RX_WAIT, RX_LIVE: begin
        if (linkFault) begin
          if (state_q == RX_LIVE) begin
            state_d = RX_HOLD; // R9
            cnt_d = RBST_CNT_RST;
          end
        end else if (rxValid) begin
          state_d = RX_LIVE; // R11
          if (rxFrame.isFast) begin
            fast_d = rxFrame.payload[RBST_FAST_MSB:RBST_FAST_LSB]; // R4
          end else begin
            slow_d = rxFrame.payload; // R5
          end
        end
      end
      RX_HOLD: begin
        if (cnt_q >= holdTimeMs) begin
          state_d = RX_WAIT; // R9
          fast_d = RBST_FAST_RST;
          slow_d = RBST_SLOW_RST;
        end else if (msTick) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = RX_WAIT;
      end
    endcase
  end

  // registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RX_WAIT;
      cnt_q <= RBST_CNT_RST;
      fast_q <= RBST_FAST_RST;
      slow_q <= RBST_SLOW_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
    end
  end

  assign fastOut = fast_q;
  assign slowOut = slow_q;

  // checks
  wait_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
    state_q == RX_WAIT |-> fast_q == RBST_FAST_RST && slow_q == RBST_SLOW_RST)
    else $error("outputs not clear while waiting for data");
  hold_stable_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
    state_q == RX_HOLD && state_d == RX_HOLD |=> $stable(fast_q)
      && $stable(slow_q))
    else $error("received state changed during hold");
  hold_expiry_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
    state_q == RX_HOLD && cnt_q >= holdTimeMs |=> state_q == RX_WAIT
      && slow_q == RBST_SLOW_RST)
    else $error("hold expiry did not clear outputs");
  slow_store_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
    state_q != RX_HOLD && !linkFault && rxValid && !rxFrame.isFast
      |=> slow_q == $past(rxFrame.payload))
    else $error("background frame not stored");
  fault_enter_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
    state_q == RX_LIVE && linkFault |=> state_q == RX_HOLD && cnt_q == 0)
    else $error("fault did not start hold timer");
  hold_cov_c: cover property (@(posedge clk) disable iff (!reset_n)
    state_q == RX_HOLD ##1 state_q == RX_WAIT);
endmodule : rbst_peer_rx

// ### rbst_peer_link.sv
// rbst_peer_link: two peer devices and the link between them and the dut.
// assumes the dut tx handshake and rx lanes run on the same clk.
`timescale 1ns/1ns
module rbst_peer_link
  import rbst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench control
  input wire logic peerOn,
  input wire logic slowReady,
  input wire logic [RBST_NUM_PEERS-1:0] faultIn,
  input wire logic [RBST_NUM_PEERS-1:0][RBST_NUM_FAST-1:0] peerFast,
  input wire logic [RBST_NUM_PEERS-1:0][RBST_NUM_SLOW-1:0] peerSlow,
  // dut transmit side
  input wire logic txValid,
  output logic txReady,
  input wire rbst_frame_t txFrame,
  // dut receive lanes
  output logic [RBST_NUM_PEERS-1:0] rxValid,
  output rbst_frame_t [RBST_NUM_PEERS-1:0] rxFrame,
  // last items taken from the dut
  output logic [RBST_NUM_FAST-1:0] lastFast,
  output logic [RBST_NUM_SLOW-1:0] lastSlow
);
  logic [2:0] cnt_q;

  // slow mode takes one frame in eight
  assign txReady = !slowReady || cnt_q == 3'h7;

  // each lane sends its peer's items in turn, silent during a fault
  always_comb begin
    for (int p = 0; p < RBST_NUM_PEERS; p++) begin
      rxValid[p] = peerOn && !faultIn[p] && cnt_q[1:0] == 2'(2 * p);
      // fast frame in the first half of the round, slow in the second
      rxFrame[p].isFast = !cnt_q[2];
      rxFrame[p].payload = cnt_q[2] ? peerSlow[p] : 24'(peerFast[p]);
      // idle lane shows the inverse, never a stale frame
      if (!rxValid[p]) rxFrame[p] = ~rxFrame[p];
    end
  end

  // record what the dut broadcast
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
      lastFast <= 4'h0;
      lastSlow <= 24'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (txValid && txReady && txFrame.isFast) lastFast <= txFrame.payload[3:0];
      if (txValid && txReady && !txFrame.isFast) lastSlow <= txFrame.payload;
    end
  end
endmodule : rbst_peer_link

// ### testbench.sv
// testbench: random and corner traffic through rbst_top and two peers.
// assumes the peer link model and a shortened millisecond tick.
`timescale 1ns/1ns
module testbench
  import rbst_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n, txValid, txReady, peerOn, slowReady;
  logic [3:0] fastTripIn, userFastInd, userFastSel, fastTripOut, lastFast;
  logic [23:0] slowSignalIn, userSlowInd, userSlowSel, slowSignalOut, lastSlow;
  logic [1:0] rxValid, linkFault, peerActive, peerPresentFlag;
  logic [1:0][3:0] peerFast;
  logic [1:0][23:0] peerSlow;
  logic [15:0] holdTimeMs;
  rbst_frame_t txFrame;
  rbst_frame_t [1:0] rxFrame;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  rbst_top #(.TICK_CYCLES(4)) dut_u (.clk(clk), .reset_n(reset_n),
    .fastTripIn(fastTripIn), .slowSignalIn(slowSignalIn),
    .userFastInd(userFastInd), .userSlowInd(userSlowInd),
    .userFastSel(userFastSel), .userSlowSel(userSlowSel),
    .txValid(txValid), .txReady(txReady), .txFrame(txFrame),
    .rxValid(rxValid), .rxFrame(rxFrame), .linkFault(linkFault),
    .peerActive(peerActive), .holdTimeMs(holdTimeMs),
    .fastTripOut(fastTripOut), .slowSignalOut(slowSignalOut),
    .peerPresentFlag(peerPresentFlag));

  rbst_peer_link peer_u (.clk(clk), .reset_n(reset_n), .peerOn(peerOn),
    .slowReady(slowReady), .faultIn(linkFault), .peerFast(peerFast),
    .peerSlow(peerSlow), .txValid(txValid), .txReady(txReady),
    .txFrame(txFrame), .rxValid(rxValid), .rxFrame(rxFrame),
    .lastFast(lastFast), .lastSlow(lastSlow));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // chosen source per item: indication where selected, else pin
  function automatic logic [23:0] pick(input logic [23:0] s, i, p);
    return (s & i) | (~s & p);
  endfunction : pick

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h545d));
    {fastTripIn, slowSignalIn, userFastInd, userSlowInd} = '0;
    {userFastSel, userSlowSel, linkFault, peerActive} = '0;
    {peerOn, slowReady, peerFast, peerSlow} = '0;
    holdTimeMs = 16'h0003;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #5 reset_n = 1'b1;
    repeat (10) @(posedge clk);
    #5;
    check(fastTripOut, 0);
    check(slowSignalOut, 0);
    peerOn = 1'b1;
    // random items both ways, last round pins and peer items all ones
    for (int i = 0; i < 8; i++) begin
      fastTripIn = 4'($urandom);
      slowSignalIn = 24'($urandom);
      userFastInd = 4'($urandom);
      userSlowInd = 24'($urandom);
      userFastSel = 4'($urandom);
      userSlowSel = 24'($urandom);
      peerFast = 8'($urandom);
      peerSlow = {24'($urandom), 24'($urandom)};
      peerActive = 2'($urandom);
      slowReady = i[0];
      if (i == 7) {fastTripIn, slowSignalIn, peerFast, peerSlow} = '1;
      repeat (60) @(posedge clk);
      #5;
      check(lastFast, pick(24'(userFastSel), 24'(userFastInd), 24'(fastTripIn)));
      check(lastSlow, pick(userSlowSel, userSlowInd, slowSignalIn));
      check(fastTripOut, peerFast[0] | peerFast[1]);
      check(slowSignalOut, peerSlow[0] | peerSlow[1]);
      check(peerPresentFlag, peerActive);
    end
    // distinct lane items so that a cleared lane shows
    peerFast = {4'h3, 4'hc};
    peerSlow = {24'h00ffff, 24'hff0f00};
    repeat (20) @(posedge clk);
    #5;
    // lane fault with long hold, then with zero hold
    for (int h = 0; h < 2; h++) begin
      holdTimeMs = h ? 16'h0000 : 16'h0003;
      linkFault = 2'b01;
      repeat (6) @(posedge clk);
      #5;
      check(fastTripOut, h ? peerFast[1] : peerFast[0] | peerFast[1]);
      check(slowSignalOut, h ? peerSlow[1] : peerSlow[0] | peerSlow[1]);
      repeat (30) @(posedge clk);
      #5;
      check(fastTripOut, peerFast[1]);
      check(slowSignalOut, peerSlow[1]);
      linkFault = 2'b00;
      repeat (30) @(posedge clk);
      #5;
      check(fastTripOut, peerFast[0] | peerFast[1]);
      check(slowSignalOut, peerSlow[0] | peerSlow[1]);
    end
    tally_and_finish();
  end
endmodule : testbench
